// File: design/flash_block_protect_and_irq.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
module flash_block_protect_and_irq
  import flash_guard_pkg::*;
#(
  parameter int FC_DIV = FC_DIV_CYCLES,
  parameter int ROW_TMO = ROW_TMO_FC_CLOCKS,
  parameter bit HALF_CAPACITY = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire op_req_t opReq,
  input wire logic opDone,
  output op_ans_t opAns,
  output logic rowAbort,
  output logic irq
);

  // =====================================================================
  // bus decode
  logic ack_q;
  logic waitReq_q;
  logic [31:0] rdData_q;
  logic [7:0] rdSnap_q;
  logic busReq;
  logic accept;
  logic commit;
  logic [7:0] regIdx;
  logic wordAligned;
  logic hitGuard;
  logic hitIrq;
  logic hitKey;
  logic hitEvt;
  logic hitMask;
  logic hitState;

  assign busReq = read | write;
  assign accept = busReq & ~ack_q;
  assign commit = busReq & ack_q;
  assign regIdx = address[ADDR_W-1:2];
  assign wordAligned = address[1:0] == 2'h0;
  assign hitGuard = wordAligned & (regIdx == IDX_GUARD);
  assign hitIrq = wordAligned & (regIdx == IDX_IRQ);
  assign hitKey = wordAligned & (regIdx == IDX_KEY);
  assign hitEvt = wordAligned & (regIdx == IDX_EVT);
  assign hitMask = wordAligned & (regIdx == IDX_MASK);
  assign hitState = wordAligned & (regIdx == IDX_STATE);

  logic wrGuard;
  logic wrIrq;
  logic wrKey;
  logic wrEvt;
  logic wrMask;
  logic rdIrq;

  assign wrGuard = commit & write & hitGuard;
  assign wrIrq = commit & write & hitIrq;
  assign wrKey = commit & write & hitKey;
  assign wrEvt = commit & write & hitEvt;
  assign wrMask = commit & write & hitMask;
  assign rdIrq = commit & read & hitIrq;

  // =====================================================================
  // key unlock and guard register
  logic [7:0] guard_q;
  logic [7:0] guard_d;
  logic unlocked_q;
  logic unlocked_d;

  assign unlocked_d = wrKey ? (writedata[7:0] == UNLOCK_KEY)
                    : (wrGuard ? 1'b0 : unlocked_q);
  assign guard_d = !wrGuard ? guard_q
                 : (unlocked_q ? writedata[7:0]
                 : GUARD_RST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_q <= GUARD_RST;
      unlocked_q <= 1'b0;
    end else begin
      guard_q <= guard_d;
      unlocked_q <= unlocked_d;
    end
  end

  // =====================================================================
  // region check
  logic [REGIONS-1:0] guardEff;
  logic [2:0] region;
  logic regionGuarded;
  logic anyGuarded;

  // the information page is not addressed here and never checked
  assign guardEff = HALF_CAPACITY ? {4'h0, guard_q[3:0]}
                  : guard_q;
  assign region = opReq.addr[FLASH_AW-1:REGION_LSB];
  assign regionGuarded = guardEff[region];
  assign anyGuarded = |guardEff;

  logic refuse;
  logic wrViol;
  logic peViol;
  logic meViol;

  assign wrViol = opReq.valid & regionGuarded
                & ((opReq.kind == OP_WRITE)
                 | (opReq.kind == OP_ROW_PROG));
  assign peViol = opReq.valid & regionGuarded
                & (opReq.kind == OP_PAGE_ERASE);
  assign meViol = opReq.valid & anyGuarded
                & (opReq.kind == OP_MASS_ERASE);
  assign refuse = wrViol | peViol | meViol;

  // =====================================================================
  // controller clock divider and operation tracking
  logic [15:0] divCnt_q;
  logic fcTick;
  logic [15:0] tmoCnt_q;
  op_state_t state_q;
  op_state_t state_d;
  logic startErase;
  logic startRow;
  logic rowTimeout;
  logic opSuccess;

  assign fcTick = divCnt_q == 16'(FC_DIV - 1);
  assign startErase = opReq.valid & ~refuse
                    & ((opReq.kind == OP_PAGE_ERASE)
                     | (opReq.kind == OP_MASS_ERASE));
  assign startRow = opReq.valid & ~refuse & (opReq.kind == OP_ROW_PROG);
  assign rowTimeout = (state_q == ST_ROW) & fcTick
                    & (tmoCnt_q == 16'(ROW_TMO - 1));
  assign opSuccess = opDone & ~rowTimeout
                   & ((state_q == ST_ERASE) | (state_q == ST_ROW));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (startRow) begin
          state_d = ST_ROW;
        end else if (startErase) begin
          state_d = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (opDone) begin
          state_d = ST_IDLE;
        end
      end
      ST_ROW: begin
        if (opDone | rowTimeout) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 16'h0000;
    end else if (fcTick) begin
      divCnt_q <= 16'h0000;
    end else begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmoCnt_q <= 16'h0000;
    end else if (state_q != ST_ROW) begin
      tmoCnt_q <= 16'h0000;
    end else if (fcTick) begin
      tmoCnt_q <= tmoCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================================
  // interrupt control register: enables and read-clear flags
  logic [7:0] irqReg_q;
  logic [7:0] flagSet;
  logic [7:0] flagClr;
  logic [7:0] irqReg_d;

  assign flagSet = {2'b00, opSuccess, 1'b0, rowTimeout,
                    wrViol, peViol, meViol};
  // only flags that were reported are cleared; a new event survives
  assign flagClr = rdIrq ? (rdSnap_q & FLAG_MASK) : 8'h00;
  assign irqReg_d[7:6] = wrIrq ? writedata[7:6] : irqReg_q[7:6];
  assign irqReg_d[5:0] = (irqReg_q[5:0] & ~flagClr[5:0])
                       | flagSet[5:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqReg_q <= IRQ_RST;
    end else begin
      irqReg_q <= irqReg_d & (FLAG_MASK | 8'hc0);
    end
  end

  // =====================================================================
  // sticky event status (write one to clear) and mask
  logic [7:0] evt_q;
  logic [7:0] evtMask_q;
  logic [7:0] evt_d;

  assign evt_d = (evt_q & ~(wrEvt ? writedata[7:0] : 8'h00)) | flagSet;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_q <= 8'h00;
      evtMask_q <= 8'h00;
    end else begin
      evt_q <= evt_d & FLAG_MASK;
      evtMask_q <= wrMask ? (writedata[7:0] & FLAG_MASK) : evtMask_q;
    end
  end

  // =====================================================================
  // interrupt request
  logic doneReq;
  logic errReq;
  logic irq_d;

  assign doneReq = irqReg_d[B_DONE_IE] & irqReg_d[B_DONE];
  assign errReq = irqReg_d[B_ERR_IE] & (|irqReg_d[3:0]);
  assign irq_d = doneReq | errReq | (|(evt_d & evtMask_q));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // =====================================================================
  // operation answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opAns <= '0;
      rowAbort <= 1'b0;
    end else begin
      opAns.grant <= opReq.valid & ~refuse;
      opAns.deny <= refuse;
      rowAbort <= rowTimeout;
    end
  end

  // =====================================================================
  // read mux and handshake
  logic [7:0] rdByte;

  assign rdByte = hitGuard ? guard_q
                : hitIrq ? irqReg_q
                : hitEvt ? evt_q
                : hitMask ? evtMask_q
                : hitState ? {5'h00, state_q == ST_ROW,
                              state_q != ST_IDLE, unlocked_q}
                : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      waitReq_q <= 1'b1;
      rdData_q <= 32'h0000_0000;
      rdSnap_q <= 8'h00;
    end else begin
      ack_q <= accept;
      waitReq_q <= ~accept;
      if (accept) begin
        rdData_q <= {24'h00_0000, rdByte};
        rdSnap_q <= irqReg_q;
      end
    end
  end

  assign readdata = rdData_q;
  assign waitrequest = waitReq_q;

endmodule

// File: design/flash_guard_pkg.sv
package flash_guard_pkg;

  // =====================================================================
  // register map (index, byte address is four times the index)
  localparam logic [7:0] IDX_GUARD = 8'hfa;
  localparam logic [7:0] IDX_IRQ = 8'hfb;
  localparam logic [7:0] IDX_KEY = 8'hfc;
  localparam logic [7:0] IDX_EVT = 8'hfd;
  localparam logic [7:0] IDX_MASK = 8'hfe;
  localparam logic [7:0] IDX_STATE = 8'hff;
  localparam int ADDR_W = 10;

  // =====================================================================
  // reset values and key
  localparam logic [7:0] GUARD_RST = 8'hff;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'ha5;

  // =====================================================================
  // interrupt control field positions
  localparam int B_DONE_IE = 7;
  localparam int B_ERR_IE = 6;
  localparam int B_DONE = 5;
  localparam int B_ROW_TMO = 3;
  localparam int B_WR_VIOL = 2;
  localparam int B_PE_VIOL = 1;
  localparam int B_ME_VIOL = 0;
  localparam logic [7:0] FLAG_MASK = 8'h2f;

  // =====================================================================
  // geometry
  localparam int FLASH_AW = 17;
  localparam int REGION_LSB = 14;
  localparam int REGIONS = 8;

  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FC_PERIOD_NS = 5100;
  localparam int FC_DIV_CYCLES =
    (FC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TMO_FC_CLOCKS = 2432;

  // =====================================================================
  // flash operation carriers
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_ROW_PROG = 2'h1,
    OP_PAGE_ERASE = 2'h2,
    OP_MASS_ERASE = 2'h3
  } op_kind_t;

  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic [FLASH_AW-1:0] addr;
  } op_req_t;

  typedef struct packed {
    logic grant;
    logic deny;
  } op_ans_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_ROW = 3'b100
  } op_state_t;

endpackage

// File: sim/flash_block_protect_and_irq_tb_top.sv
`timescale 1ns/100ps
module flash_block_protect_and_irq_tb_top
  import flash_guard_pkg::*;
;
  logic clk, rst, read, write, go, opDone, rowAbort, irq, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata;
  logic [FLASH_AW-1:0] ma;
  logic [7:0] gap, g, ie, e, q;
  logic [15:0] lf;
  op_kind_t mk;
  op_req_t opReq;
  op_ans_t opAns;
  op_req_t reqHalf;
  op_ans_t ansHalf;
  logic doneHalf;
  int n_errors, n_compared;

  flash_block_protect_and_irq #(.FC_DIV(2), .ROW_TMO(8)) i_dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .opReq(opReq), .opDone(opDone), .opAns(opAns), .rowAbort(rowAbort),
    .irq(irq));
  flash_seq_model i_seq (.clk(clk), .rst(rst), .go(go), .kind(mk),
    .addr(ma), .doneGap(gap), .opAns(opAns), .opReq(opReq),
    .opDone(opDone));
  // half-capacity variant sees the same bus and the same requests
  flash_block_protect_and_irq #(.FC_DIV(2), .ROW_TMO(8), .HALF_CAPACITY(1'b1))
    i_dut_half (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(), .waitrequest(),
    .opReq(reqHalf), .opDone(doneHalf), .opAns(ansHalf), .rowAbort(),
    .irq());
  flash_seq_model i_seq_half (.clk(clk), .rst(rst), .go(go), .kind(mk),
    .addr(ma), .doneGap(gap), .opAns(ansHalf), .opReq(reqHalf),
    .opDone(doneHalf));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // =====
  // helpers
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic expDeny(op_kind_t k, logic [16:0] a);
    return (k == OP_MASS_ERASE) ? |g : g[a[16:14]];
  endfunction
  function automatic logic expHalf(op_kind_t k, logic [16:0] a);
    return (k == OP_MASS_ERASE) ? |g[3:0] : !a[16] && g[a[16:14]];
  endfunction
  function automatic logic expIrq();
    return (ie[7] & e[5]) | (ie[6] & |e[3:0]);
  endfunction
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic acc(logic wr, logic [7:0] idx, logic [7:0] wd);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, wd};
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic setGuard(logic [7:0] v);
    acc(1'b1, IDX_KEY, UNLOCK_KEY);
    acc(1'b1, IDX_GUARD, v);
    g = v;
  endtask
  task automatic setIe(logic [7:0] v);
    acc(1'b1, IDX_IRQ, v);
    ie = v & 8'hc0;
  endtask
  task automatic op(op_kind_t k, logic [16:0] a, logic [7:0] d);
    int n;
    logic dn;
    n = 0;
    dn = expDeny(k, a);
    @(posedge clk);
    go <= 1'b1;
    mk <= k;
    ma <= a;
    gap <= d;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (opAns === 2'b00 && n < 8);
    check("deny", 8'(opAns.deny), 8'(dn));
    check("grant", 8'(opAns.grant), 8'(!dn));
    check("half deny", 8'(ansHalf.deny), 8'(expHalf(k, a)));
    if (dn) e[k == OP_MASS_ERASE ? 0 : k == OP_PAGE_ERASE ? 1 : 2] = 1'b1;
    else if (k != OP_WRITE && d != 8'h00) e[5] = 1'b1;
    repeat (d + 4) @(posedge clk);
  endtask
  task automatic chkSt();
    check("irq", 8'(irq), 8'(expIrq()));
    acc(1'b0, IDX_IRQ, 8'h00);
    check("status", q, ie | e);
    e = 8'h00;
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // =====
  // tests
  initial begin
    rst = 1'b1;
    {read, write, go, address, writedata, ma, gap} = '0;
    mk = OP_WRITE;
    {ie, e} = '0;
    g = 8'hff;
    lf = 16'h002a;
    {n_errors, n_compared} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, IDX_GUARD, 8'h00);
    check("guard rst", q, GUARD_RST);
    acc(1'b0, IDX_IRQ, 8'h00);
    check("irq rst", q, IRQ_RST);
    acc(1'b0, 8'h20, 8'h00);
    check("unmapped", q, 8'h00);
    $display("test reset done");
    setGuard(8'h00);
    acc(1'b0, IDX_GUARD, 8'h00);
    check("unlocked", q, 8'h00);
    acc(1'b1, IDX_GUARD, 8'h5a);
    acc(1'b0, IDX_GUARD, 8'h00);
    check("locked", q, 8'hff);
    g = 8'hff;
    $display("test lock done");
    for (int i = 0; i < 48; i++) begin
      lf = lfsr(lf);
      if (i % 8 == 0) begin
        setGuard(i == 8 ? 8'h00 : lf[7:0]);
        setIe({lf[15:14], 6'h00});
      end
      op(op_kind_t'(lf[9:8]), {lf[12:10], lf[13:0]}, {5'h00, lf[2:0]} + 8'h01);
      chkSt();
    end
    $display("test random ops done");
    setGuard(8'h00);
    setIe(8'h40);
    op(OP_ROW_PROG, 17'h1c000, 8'h00);
    for (int k = 0; k < 60 && rowAbort !== 1'b1; k++) @(posedge clk);
    check("abort", 8'(rowAbort), 8'h01);
    e[3] = 1'b1;
    repeat (3) @(posedge clk);
    chkSt();
    repeat (3) @(posedge clk);
    check("irq clear", 8'(irq), 8'h00);
    $display("test timeout done");
    // sticky event path: a masked-in violation holds irq until written off
    setIe(8'h00);
    acc(1'b1, IDX_EVT, 8'hff);
    acc(1'b1, IDX_MASK, 8'h04);
    setGuard(8'hff);
    op(OP_WRITE, 17'h00000, 8'h01);
    check("evt irq", 8'(irq), 8'h01);
    acc(1'b0, IDX_EVT, 8'h00);
    check("evt", q, 8'h04);
    acc(1'b1, IDX_EVT, 8'h04);
    repeat (2) @(posedge clk);
    check("evt clear", 8'(irq), 8'h00);
    chkSt();
    $display("test event done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule

// File: sim/flash_guard_sva.sv
`timescale 1ns/100ps
module flash_guard_sva
  import flash_guard_pkg::*;
#(
  parameter int FC_DIV = FC_DIV_CYCLES,
  parameter int ROW_TMO = ROW_TMO_FC_CLOCKS,
  parameter bit HALF_CAPACITY = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire op_req_t opReq,
  input wire logic opDone,
  input wire op_ans_t opAns,
  input wire logic rowAbort,
  input wire logic irq
);
  localparam int TMO = ROW_TMO * FC_DIV;
  logic rowOn_q;
  logic [31:0] rowCnt_q;
  op_kind_t kind_q;
  wire logic cause = opDone | opAns.deny | rowAbort | !waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // =====
  // age of the row program since its grant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rowOn_q <= 1'b0;
      rowCnt_q <= '0;
      kind_q <= OP_WRITE;
    end else begin
      kind_q <= opReq.kind;
      if (opAns.grant && kind_q == OP_ROW_PROG && !rowOn_q) begin
        rowOn_q <= 1'b1;
        rowCnt_q <= '0;
      end else if (opDone || rowAbort) begin
        rowOn_q <= 1'b0;
      end else if (rowOn_q) begin
        rowCnt_q <= rowCnt_q + 32'h0000_0001;
      end
    end
  end
  // =====
  // properties
  AST_ACK_NEXT: assert property ((read | write) && waitrequest |=>
    !waitrequest) else $error("request not answered");
  AST_ACK_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("ack longer than one cycle");
  AST_ANS_ONE: assert property (opReq.valid |=>
    opAns.grant != opAns.deny) else $error("request not answered once");
  AST_ANS_CAUSE: assert property (opAns.grant | opAns.deny |->
    $past(opReq.valid)) else $error("answer without request");
  AST_ROW_TMO: assert property (rowAbort |-> rowOn_q &&
    rowCnt_q >= TMO - FC_DIV && rowCnt_q <= TMO - 1)
    else $error("abort time");
  AST_ROW_LATE: assert property (rowOn_q |-> rowCnt_q <= TMO + 2)
    else $error("row program not aborted");
  AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(!waitrequest) ||
    $past(!waitrequest, 2)) else $error("irq fell without access");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> cause ||
    $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("irq without event");
endmodule

bind flash_block_protect_and_irq flash_guard_sva #(.FC_DIV(FC_DIV),
  .ROW_TMO(ROW_TMO), .HALF_CAPACITY(HALF_CAPACITY)) i_sva (.clk(clk),
  .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .opReq(opReq), .opDone(opDone), .opAns(opAns), .rowAbort(rowAbort),
  .irq(irq));

// File: sim/flash_seq_model.sv
`timescale 1ns/100ps
module flash_seq_model
  import flash_guard_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire op_kind_t kind,
  input wire logic [FLASH_AW-1:0] addr,
  input wire logic [7:0] doneGap,
  input wire op_ans_t opAns,
  output op_req_t opReq,
  output logic opDone
);
  op_kind_t kind_q;
  logic [7:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opReq <= '0;
      opDone <= 1'b0;
      kind_q <= OP_WRITE;
      cnt_q <= 8'h00;
    end else begin
      // idle fields toggle so stale values are never trusted
      opReq <= go ? {1'b1, kind, addr} : {1'b0, ~opReq[FLASH_AW+1:0]};
      opDone <= (cnt_q == 8'h01);
      if (opReq.valid) kind_q <= opReq.kind;
      // gap of zero never finishes, forcing the row program time-out
      if (opAns.grant && kind_q != OP_WRITE) cnt_q <= doneGap;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule
